// *** design/nrs_axil_slave.sv ***
// AXI4-Lite slave front end turning bus transfers into register strobes
// assumes the register bank answers hit and read data combinationally
`timescale 1ns/10ps
`default_nettype none

module nrs_axil_slave (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // write address and data
   input wire logic [nrs_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [nrs_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read
   input wire logic [nrs_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [nrs_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // register side
   nrs_reg_if.bus rif
);

   typedef struct packed {
      logic aw_held;
      logic [nrs_pkg::IDX_W-1:0] aw_idx;
      logic awready;
      logic w_held;
      logic [7:0] wdata;
      logic wlane0;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [nrs_pkg::DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } nrs_axi_t;

   nrs_axi_t s;
   nrs_axi_t next_s;

   // write fires in the first cycle both halves are held and no response is pending
   assign rif.wr_en = s.aw_held & s.w_held & ~s.bvalid;
   assign rif.wr_idx = s.aw_idx;
   assign rif.wr_data = s.wdata;
   assign rif.wr_lane0 = s.wlane0;
   assign rif.rd_en = s_axi_arvalid & s.arready;
   assign rif.rd_idx = s_axi_araddr[nrs_pkg::ADDR_W-1:2];

   always_comb
   begin
      next_s = s;
      if (s_axi_awvalid && s.awready)
      begin
         next_s.aw_held = 1'b1;
         next_s.aw_idx = s_axi_awaddr[nrs_pkg::ADDR_W-1:2];
      end
      if (s_axi_wvalid && s.wready)
      begin
         next_s.w_held = 1'b1;
         next_s.wdata = s_axi_wdata[7:0];
         next_s.wlane0 = s_axi_wstrb[0];
      end
      if (rif.wr_en)
      begin
         next_s.aw_held = 1'b0;
         next_s.w_held = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = rif.wr_hit ? nrs_pkg::RESP_OKAY : nrs_pkg::RESP_SLVERR;
      end
      else if (s.bvalid && s_axi_bready)
      begin
         next_s.bvalid = 1'b0;
      end
      if (rif.rd_en)
      begin
         next_s.rvalid = 1'b1;
         next_s.rdata = {24'h000000, rif.rd_data};
         next_s.rresp = rif.rd_hit ? nrs_pkg::RESP_OKAY : nrs_pkg::RESP_SLVERR;
      end
      else if (s.rvalid && s_axi_rready)
      begin
         next_s.rvalid = 1'b0;
      end
      next_s.awready = ~next_s.aw_held;
      next_s.wready = ~next_s.w_held;
      next_s.arready = ~next_s.rvalid;
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;

endmodule : nrs_axil_slave

`default_nettype wire

// *** design/nrs_pkg.sv ***
// constants shared by the reader status register block
// assumes a 32-bit AXI4-Lite register bus and an 8-bit register map
package nrs_pkg;

   // bus shape
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int IDX_W = 6;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // register indices, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CRC_FIFO = 6'h07;
   localparam logic [IDX_W-1:0] IDX_MODEM = 6'h08;
   localparam logic [IDX_W-1:0] IDX_THRESH = 6'h0B;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h20;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h21;

   // first status register fields
   localparam int S1_CRC_MATCH = 6;
   localparam int S1_CRC_DONE = 5;
   localparam int S1_IRQ = 4;
   localparam int S1_TIMER = 3;
   localparam int S1_NEAR_FULL = 1;
   localparam int S1_NEAR_EMPTY = 0;

   // second status register fields
   localparam int S2_ALARM_CLEAR = 7;
   localparam int S2_CIPHER = 3;
   localparam int S2_STATE_LSB = 0;

   // interrupt status and mask layout
   localparam int N_IRQ = 3;
   localparam int IRQ_CRC_DONE = 0;
   localparam int IRQ_OVERTEMP = 1;
   localparam int IRQ_AUTH = 2;

   // reset values and sizes
   localparam logic [7:0] RST_CRC_FIFO = 8'h21;
   localparam logic [7:0] RST_MODEM = 8'h00;
   localparam logic [5:0] RST_THRESH = 6'h08;
   localparam logic [N_IRQ-1:0] RST_IRQ_MASK = 3'h0;
   localparam logic [6:0] FIFO_DEPTH = 7'h40;

   // radio link state codes, code 7 is undefined
   typedef enum logic [2:0] {
      LINK_IDLE = 3'h0,
      LINK_WAIT_START = 3'h1,
      LINK_TX_WAIT = 3'h2,
      LINK_TX = 3'h3,
      LINK_RX_WAIT = 3'h4,
      LINK_WAIT_DATA = 3'h5,
      LINK_RX = 3'h6,
      LINK_UNDEF = 3'h7
   } nrs_link_state_t;

endpackage : nrs_pkg

// *** design/nrs_reg_if.sv ***
// register access strobes between bus slave and register bank
// assumes one clock; strobes are single-cycle and combinational
`timescale 1ns/10ps
`default_nettype none

interface nrs_reg_if;
   logic wr_en;
   logic [nrs_pkg::IDX_W-1:0] wr_idx;
   logic [7:0] wr_data;
   logic wr_lane0;
   logic wr_hit;
   logic rd_en;
   logic [nrs_pkg::IDX_W-1:0] rd_idx;
   logic [7:0] rd_data;
   logic rd_hit;

   modport bus (output wr_en, wr_idx, wr_data, wr_lane0, rd_en, rd_idx,
                input wr_hit, rd_data, rd_hit);
   modport regs (input wr_en, wr_idx, wr_data, wr_lane0, rd_en, rd_idx,
                 output wr_hit, rd_data, rd_hit);
endinterface : nrs_reg_if

`default_nettype wire

// *** design/nrs_status_regs.sv ***
// reader status register bank: crc, interrupt, timer, fifo, cipher, modem
// assumes engine status inputs on core_clk; sensor levels are asynchronous
`timescale 1ns/10ps
`default_nettype none

module nrs_status_regs #(
   parameter logic [6:0] FIFO_SIZE = nrs_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // AXI4-Lite write
   input wire logic [nrs_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [nrs_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [nrs_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [nrs_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // crc coprocessor
   input wire logic crc_start,
   input wire logic crc_finish,
   input wire logic crc_residue_zero,
   input wire logic crc_compute_cmd,
   // timer and fifo
   input wire logic timer_active,
   input wire logic [6:0] fifo_level,
   output logic [5:0] fifo_threshold,
   // interrupt sources and enables
   input wire logic [7:0] common_irq_req,
   input wire logic [7:0] common_interrupt_enables,
   input wire logic [7:0] misc_irq_req,
   input wire logic [7:0] misc_interrupt_enables,
   // modem and authentication
   input wire logic [2:0] radio_link_state,
   input wire logic card_authenticate_ok,
   output logic card_cipher_active,
   // temperature sensor pins
   input wire logic overtemp_detect,
   input wire logic temp_below_limit,
   output logic overtemp_flag,
   output logic antenna_drivers_off,
   // block interrupt
   output logic irq
);

   typedef struct packed {
      logic crc_match_flag;
      logic crc_done_flag;
      logic irq_pending;
      logic timer_active;
      logic fifo_near_full;
      logic fifo_near_empty;
      logic overtemp_alarm_clear;
      logic card_cipher_active;
      nrs_pkg::nrs_link_state_t radio_link_state;
      logic overtemp_flag;
      logic [5:0] fifo_threshold;
      logic [nrs_pkg::N_IRQ-1:0] irq_status;
      logic [nrs_pkg::N_IRQ-1:0] irq_mask;
      logic irq;
   } nrs_regs_t;

   nrs_regs_t s;
   nrs_regs_t next_s;
   logic [1:0] temp_sync;
   logic hot;
   logic cool;
   logic [nrs_pkg::N_IRQ-1:0] events;
   logic [6:0] free_space;

   nrs_reg_if rif ();

   ////////////////////////////////////////////////////////////////////////////////
   // bus and pin front ends

   nrs_axil_slave u_bus (
      .core_clk(core_clk),
      .rstn(rstn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .rif(rif.bus)
   );

   // sensor outputs are asynchronous to core_clk
   nrs_sync3 #(
      .WIDTH(2)
   ) u_temp_sync (
      .core_clk(core_clk),
      .rstn(rstn),
      .async_in({temp_below_limit, overtemp_detect}),
      .sync_out(temp_sync)
   );

   assign hot = temp_sync[0];
   assign cool = temp_sync[1];

   ////////////////////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic logic is_mapped(input logic [nrs_pkg::IDX_W-1:0] idx);
      is_mapped = (idx == nrs_pkg::IDX_CRC_FIFO) || (idx == nrs_pkg::IDX_MODEM) ||
                  (idx == nrs_pkg::IDX_THRESH) || (idx == nrs_pkg::IDX_IRQ_STAT) ||
                  (idx == nrs_pkg::IDX_IRQ_MASK);
   endfunction : is_mapped

   function automatic logic [7:0] read_value(input logic [nrs_pkg::IDX_W-1:0] idx,
                                             input nrs_regs_t r);
      logic [7:0] v;
      v = 8'h00;
      unique case (idx)
         nrs_pkg::IDX_CRC_FIFO:
         begin
            v[nrs_pkg::S1_CRC_MATCH] = r.crc_match_flag;
            v[nrs_pkg::S1_CRC_DONE] = r.crc_done_flag;
            v[nrs_pkg::S1_IRQ] = r.irq_pending;
            v[nrs_pkg::S1_TIMER] = r.timer_active;
            v[nrs_pkg::S1_NEAR_FULL] = r.fifo_near_full;
            v[nrs_pkg::S1_NEAR_EMPTY] = r.fifo_near_empty;
         end
         nrs_pkg::IDX_MODEM:
         begin
            v[nrs_pkg::S2_ALARM_CLEAR] = r.overtemp_alarm_clear;
            v[nrs_pkg::S2_CIPHER] = r.card_cipher_active;
            v[nrs_pkg::S2_STATE_LSB +: 3] = r.radio_link_state;
         end
         nrs_pkg::IDX_THRESH:
         begin
            v[5:0] = r.fifo_threshold;
         end
         nrs_pkg::IDX_IRQ_STAT:
         begin
            v[nrs_pkg::N_IRQ-1:0] = r.irq_status;
         end
         nrs_pkg::IDX_IRQ_MASK:
         begin
            v[nrs_pkg::N_IRQ-1:0] = r.irq_mask;
         end
         default:
         begin
            v = 8'h00;
         end
      endcase
      read_value = v;
   endfunction : read_value

   assign rif.rd_hit = is_mapped(rif.rd_idx);
   assign rif.rd_data = read_value(rif.rd_idx, s);
   assign rif.wr_hit = is_mapped(rif.wr_idx);

   assign free_space = FIFO_SIZE - fifo_level;

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      next_s = s;
      events = '0;

      // crc result tracks the coprocessor, undefined during radio traffic
      if (crc_start)
      begin
         next_s.crc_match_flag = 1'b0;
         if (crc_compute_cmd)
         begin
            next_s.crc_done_flag = 1'b0;
         end
      end
      if (crc_finish)
      begin
         next_s.crc_match_flag = crc_residue_zero;
         if (crc_compute_cmd)
         begin
            next_s.crc_done_flag = 1'b1;
            events[nrs_pkg::IRQ_CRC_DONE] = 1'b1;
         end
      end

      next_s.irq_pending = |(common_irq_req & common_interrupt_enables) |
                           |(misc_irq_req & misc_interrupt_enables);
      next_s.timer_active = timer_active;
      next_s.fifo_near_full = (free_space <= {1'b0, s.fifo_threshold});
      next_s.fifo_near_empty = (fifo_level <= {1'b0, s.fifo_threshold});
      next_s.radio_link_state = nrs_pkg::nrs_link_state_t'(radio_link_state);

      // software writes, only the low byte lane carries data
      if (rif.wr_en && rif.wr_lane0)
      begin
         unique case (rif.wr_idx)
            nrs_pkg::IDX_MODEM:
            begin
               next_s.overtemp_alarm_clear = rif.wr_data[nrs_pkg::S2_ALARM_CLEAR];
               if (!rif.wr_data[nrs_pkg::S2_CIPHER])
               begin
                  next_s.card_cipher_active = 1'b0;
               end
            end
            nrs_pkg::IDX_THRESH:
            begin
               next_s.fifo_threshold = rif.wr_data[5:0];
            end
            nrs_pkg::IDX_IRQ_STAT:
            begin
               next_s.irq_status = s.irq_status & ~rif.wr_data[nrs_pkg::N_IRQ-1:0];
            end
            nrs_pkg::IDX_IRQ_MASK:
            begin
               next_s.irq_mask = rif.wr_data[nrs_pkg::N_IRQ-1:0];
            end
            default:
            begin
               next_s.fifo_threshold = s.fifo_threshold;
            end
         endcase
      end

      // authentication wins over a software clear in the same cycle
      if (card_authenticate_ok)
      begin
         next_s.card_cipher_active = 1'b1;
         events[nrs_pkg::IRQ_AUTH] = ~s.card_cipher_active;
      end

      // alarm removal needs a cool die; a live detection always wins
      if (s.overtemp_alarm_clear && cool)
      begin
         next_s.overtemp_flag = 1'b0;
      end
      if (hot)
      begin
         next_s.overtemp_flag = 1'b1;
         events[nrs_pkg::IRQ_OVERTEMP] = ~s.overtemp_flag;
      end

      // sticky status: new events beat a write-one clear
      next_s.irq_status = next_s.irq_status | events;
      next_s.irq = |(next_s.irq_status & next_s.irq_mask);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s <= '0;
         s.crc_match_flag <= nrs_pkg::RST_CRC_FIFO[nrs_pkg::S1_CRC_MATCH];
         s.crc_done_flag <= nrs_pkg::RST_CRC_FIFO[nrs_pkg::S1_CRC_DONE];
         s.irq_pending <= nrs_pkg::RST_CRC_FIFO[nrs_pkg::S1_IRQ];
         s.timer_active <= nrs_pkg::RST_CRC_FIFO[nrs_pkg::S1_TIMER];
         s.fifo_near_full <= nrs_pkg::RST_CRC_FIFO[nrs_pkg::S1_NEAR_FULL];
         s.fifo_near_empty <= nrs_pkg::RST_CRC_FIFO[nrs_pkg::S1_NEAR_EMPTY];
         s.overtemp_alarm_clear <= nrs_pkg::RST_MODEM[nrs_pkg::S2_ALARM_CLEAR];
         s.card_cipher_active <= nrs_pkg::RST_MODEM[nrs_pkg::S2_CIPHER];
         s.radio_link_state <= nrs_pkg::LINK_IDLE;
         s.fifo_threshold <= nrs_pkg::RST_THRESH;
         s.irq_mask <= nrs_pkg::RST_IRQ_MASK;
      end
      else
      begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from flops

   assign fifo_threshold = s.fifo_threshold;
   assign card_cipher_active = s.card_cipher_active;
   assign overtemp_flag = s.overtemp_flag;
   assign antenna_drivers_off = s.overtemp_flag;
   assign irq = s.irq;

endmodule : nrs_status_regs

`default_nettype wire

// *** design/nrs_sync3.sv ***
// three-stage synchroniser with agreement filter
// assumes asynchronous level inputs; output moves once stages 2 and 3 agree
`timescale 1ns/10ps
`default_nettype none

module nrs_sync3 #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] ff1;
      logic [WIDTH-1:0] ff2;
      logic [WIDTH-1:0] ff3;
      logic [WIDTH-1:0] out;
   } nrs_sync_t;

   nrs_sync_t s;
   nrs_sync_t next_s;

   always_comb
   begin
      next_s = s;
      next_s.ff1 = async_in;
      next_s.ff2 = s.ff1;
      next_s.ff3 = s.ff2;
      for (int i = 0; i < WIDTH; i++)
      begin
         if (s.ff2[i] == s.ff3[i])
         begin
            next_s.out[i] = s.ff3[i];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign sync_out = s.out;

endmodule : nrs_sync3

`default_nettype wire

// *** test/nfc_reader_status_regs_tb.sv ***
// self-checking bench for the reader status register bank
// assumes the host model as bus master and the bound checker
`timescale 1ns/10ps
`default_nettype none

module nfc_reader_status_regs_tb;
   typedef struct packed {
      logic [6:0] lvl;
      logic tmr;
      logic [7:0] creq, cen, mreq, men;
      logic [2:0] st;
      logic [7:0] exp1;
   } nrs_row_t;
   localparam logic [7:0] A_S1 = {nrs_pkg::IDX_CRC_FIFO, 2'h0};
   localparam logic [7:0] A_S2 = {nrs_pkg::IDX_MODEM, 2'h0};
   localparam logic [7:0] A_TH = {nrs_pkg::IDX_THRESH, 2'h0};
   localparam logic [7:0] A_IS = {nrs_pkg::IDX_IRQ_STAT, 2'h0};
   localparam logic [7:0] A_MK = {nrs_pkg::IDX_IRQ_MASK, 2'h0};
   localparam logic [1:0] OK = nrs_pkg::RESP_OKAY;
   // threshold 8 from reset: near full from 56 bytes, near empty up to 8
   localparam nrs_row_t ROWS [8] = '{
      '{7'h00, 1'h0, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 8'h21},
      '{7'h08, 1'h1, 8'h01, 8'h00, 8'h00, 8'h00, 3'h1, 8'h29},
      '{7'h09, 1'h0, 8'h01, 8'h01, 8'h00, 8'h00, 3'h2, 8'h30},
      '{7'h37, 1'h1, 8'h00, 8'hFF, 8'h04, 8'h00, 3'h3, 8'h28},
      '{7'h38, 1'h0, 8'h00, 8'h00, 8'h04, 8'h04, 3'h4, 8'h32},
      '{7'h40, 1'h0, 8'h80, 8'h80, 8'h00, 8'h00, 3'h5, 8'h32},
      '{7'h14, 1'h0, 8'h00, 8'h00, 8'h00, 8'h00, 3'h6, 8'h20},
      '{7'h08, 1'h0, 8'h00, 8'h00, 8'h00, 8'h00, 3'h7, 8'h21}};
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic crc_start, crc_finish, crc_residue_zero, crc_compute_cmd, timer_active;
   logic [6:0] fifo_level;
   logic [5:0] fifo_threshold;
   logic [7:0] common_irq_req, common_interrupt_enables, misc_irq_req, misc_interrupt_enables;
   logic [2:0] radio_link_state;
   logic card_authenticate_ok, card_cipher_active, overtemp_detect, temp_below_limit;
   logic overtemp_flag, antenna_drivers_off, irq;
   int n_errors = 0;
   int num_checks = 0;

   always #4 core_clk = ~core_clk;

   // every port meets the bench signal of the same name
   nrs_host_model nrs_host_model_inst (.*);
   nrs_status_regs #(.FIFO_SIZE(7'h40)) nrs_status_regs_inst (.*);

   task automatic fail(input logic [31:0] got, input logic [31:0] exp);
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
   endtask : fail

   task automatic check(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      nrs_host_model_inst.rd(a, d, r);
      num_checks++;
      if (d !== {24'h0, exp} || r !== er)
         fail(d, {24'h0, exp});
   endtask : check

   task automatic cmp(input logic got, input logic exp);
      num_checks++;
      if (got !== exp)
         fail({31'h0, got}, {31'h0, exp});
   endtask : cmp

   task automatic put(input logic [7:0] a, input logic [7:0] d);
      logic [1:0] r;
      nrs_host_model_inst.wr(a, {24'h0, d}, r);
      num_checks++;
      if (r !== OK)
         fail({30'h0, r}, 32'h0);
   endtask : put

   task automatic crc_run(input logic cmd, input logic zero, input logic [7:0] mid,
                          input logic [7:0] fin);
      {crc_compute_cmd, crc_start} <= {cmd, 1'b1};
      @(posedge core_clk);
      crc_start <= 1'b0;
      check(A_S1, mid, OK);
      {crc_residue_zero, crc_finish} <= {zero, 1'b1};
      @(posedge core_clk);
      crc_finish <= 1'b0;
      check(A_S1, fin, OK);
   endtask : crc_run

   task automatic print_verdict;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   initial
   begin
      #(20000 * 8);
      n_errors++;
      print_verdict();
   end

   initial
   begin
      {crc_start, crc_finish, crc_residue_zero, crc_compute_cmd, timer_active} = '0;
      {fifo_level, common_irq_req, common_interrupt_enables, misc_irq_req} = '0;
      {misc_interrupt_enables, radio_link_state, card_authenticate_ok, overtemp_detect} = '0;
      temp_below_limit = 1'b1;
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge core_clk);
      check(A_S1, 8'h21, OK);
      check(A_S2, 8'h00, OK);
      check(A_TH, 8'h08, OK);
      check(A_MK, 8'h00, OK);
      check(8'h40, 8'h00, nrs_pkg::RESP_SLVERR);
      put(A_S1, 8'hFF);
      put(A_S2, 8'h77);
      check(A_S1, 8'h21, OK);
      check(A_S2, 8'h00, OK);
      foreach (ROWS[i])
      begin
         {fifo_level, timer_active, common_irq_req, common_interrupt_enables, misc_irq_req,
          misc_interrupt_enables, radio_link_state} <= ROWS[i][50:8];
         repeat (2) @(posedge core_clk);
         check(A_S1, ROWS[i].exp1, OK);
         check(A_S2, {5'h0, ROWS[i].st}, OK);
      end
      // crc results read with the radio idle only
      radio_link_state <= 3'h0;
      crc_run(1'b1, 1'b1, 8'h01, 8'h61);
      crc_run(1'b0, 1'b0, 8'h21, 8'h21);
      crc_run(1'b1, 1'b0, 8'h01, 8'h21);
      check(A_IS, 8'h01, OK);
      cmp(irq, 1'b0);
      put(A_MK, 8'h01);
      repeat (2) @(posedge core_clk);
      cmp(irq, 1'b1);
      put(A_IS, 8'h01);
      repeat (2) @(posedge core_clk);
      cmp(irq, 1'b0);
      card_authenticate_ok <= 1'b1;
      @(posedge core_clk);
      card_authenticate_ok <= 1'b0;
      check(A_S2, 8'h08, OK);
      cmp(card_cipher_active, 1'b1);
      put(A_S2, 8'h00);
      put(A_S2, 8'h08);
      check(A_S2, 8'h00, OK);
      cmp(card_cipher_active, 1'b0);
      {overtemp_detect, temp_below_limit} <= 2'h2;
      repeat (10) @(posedge core_clk);
      cmp(overtemp_flag, 1'b1);
      cmp(antenna_drivers_off, 1'b1);
      put(A_S2, 8'h80);
      overtemp_detect <= 1'b0;
      repeat (10) @(posedge core_clk);
      cmp(overtemp_flag, 1'b1);
      temp_below_limit <= 1'b1;
      repeat (10) @(posedge core_clk);
      cmp(overtemp_flag, 1'b0);
      check(A_S2, 8'h80, OK);
      check(A_IS, 8'h06, OK);
      // reserved threshold bits dropped; level 8 now inside both warnings
      put(A_TH, 8'hFF);
      check(A_TH, 8'h3F, OK);
      check(A_S1, 8'h23, OK);
      cmp(fifo_threshold == 6'h3F, 1'b1);
      // mid-run reset must bring back the reset values
      rstn <= 1'b0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge core_clk);
      cmp(fifo_threshold == 6'h08, 1'b1);
      check(A_S2, 8'h00, OK);
      check(A_S1, 8'h21, OK);
      print_verdict();
   end
endmodule : nfc_reader_status_regs_tb

`default_nettype wire

// *** test/nrs_host_model.sv ***
// host processor model: AXI4-Lite master offering word read and write tasks
// assumes the slave answers in its own time; the bench watchdog ends a hang
`timescale 1ns/10ps
`default_nettype none

module nrs_host_model (
   // clock
   input wire logic core_clk,
   // write channels
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   // read channels
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   initial
   begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
      logic aw_open;
      logic w_open;
      @(posedge core_clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      aw_open = 1'b1;
      w_open = 1'b1;
      do
      begin
         @(posedge core_clk);
         if (aw_open && s_axi_awready)
         begin
            aw_open = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w_open && s_axi_wready)
         begin
            w_open = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (aw_open || w_open || !s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      @(posedge core_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do
         @(posedge core_clk);
      while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do
         @(posedge core_clk);
      while (!s_axi_rvalid);
      d = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
endmodule : nrs_host_model

`default_nettype wire

// *** test/nrs_status_regs_props.sv ***
// checker for the reader status register bank, bound to its top module
// assumes one clock domain and the active-low asynchronous reset
`timescale 1ns/10ps
`default_nettype none

module nrs_status_regs_props (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // bus
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // cipher and temperature
   input wire logic card_authenticate_ok,
   input wire logic card_cipher_active,
   input wire logic overtemp_detect,
   input wire logic overtemp_flag,
   input wire logic antenna_drivers_off
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence rd_waiting;
      s_axi_rvalid && !s_axi_rready;
   endsequence

   chk_read_answer: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered one cycle after address");
   chk_read_hold: assert property (rd_waiting |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before rready");
   chk_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("rvalid stayed after handshake");
   chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped before bready");
   chk_cipher_set: assert property (card_authenticate_ok |=> card_cipher_active)
      else $error("cipher not set after authentication");
   chk_cipher_cause: assert property ($rose(card_cipher_active) |-> $past(card_authenticate_ok))
      else $error("cipher set without authentication");
   chk_antenna_off: assert property (overtemp_flag == antenna_drivers_off)
      else $error("antenna drivers not following alarm");
   chk_hot_alarm: assert property (overtemp_detect [*8] |=> overtemp_flag)
      else $error("alarm not raised while hot");
endmodule : nrs_status_regs_props

bind nrs_status_regs nrs_status_regs_props nrs_status_regs_props_inst (.core_clk, .rstn,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid,
   .s_axi_bready, .card_authenticate_ok, .card_cipher_active, .overtemp_detect, .overtemp_flag,
   .antenna_drivers_off);

`default_nettype wire
